// File: hw/lcd_bias_pkg.sv
// constants and types for the software-driven lcd bias driver
package lcd_bias_pkg;

    // ------------------------------------------------------------------
    // register map (word index on the plain register port)
    // ------------------------------------------------------------------
    localparam logic [2:0] ADDR_CTRL      = 3'h0;
    localparam logic [2:0] ADDR_SEG_LO    = 3'h1;
    localparam logic [2:0] ADDR_SEG_MID   = 3'h2;
    localparam logic [2:0] ADDR_SEG_HI    = 3'h3;
    localparam logic [2:0] ADDR_PORT_A    = 3'h4;
    localparam logic [2:0] ADDR_SEG_DAT0  = 3'h5;
    localparam logic [2:0] ADDR_SEG_DAT1  = 3'h6;
    localparam logic [2:0] ADDR_SEG_DAT2  = 3'h7;

    // ------------------------------------------------------------------
    // control register fields
    // ------------------------------------------------------------------
    localparam int CTRL_FRAME_BIT  = 7;
    localparam int CTRL_ISEL_HI    = 6;
    localparam int CTRL_ISEL_LO    = 5;
    localparam int CTRL_MASTER_BIT = 4;
    localparam int CTRL_COM_HI     = 3;
    localparam int CTRL_COM_LO     = 0;

    localparam logic [7:0] CTRL_RESET     = 8'h00;
    localparam logic [7:0] SEG_SEL_RESET  = 8'h00;
    localparam logic [7:0] PORT_RESET     = 8'h00;
    localparam logic [3:0] SEG_HI_MASK    = 4'hF;

    localparam int NUM_COM = 4;
    localparam int NUM_SEG = 20;

    // first-port data bits feeding the common pins
    localparam int COM_DATA_BIT0 = 0;
    localparam int COM_DATA_BIT1 = 1;
    localparam int COM_DATA_BIT2 = 2;
    localparam int COM_DATA_BIT3 = 4;

    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        LVL_GND       = 2'b00,
        LVL_ONE_THIRD = 2'b01,
        LVL_TWO_THIRD = 2'b10,
        LVL_SUPPLY    = 2'b11
    } lcd_level_t;

    typedef struct packed {
        logic       frame;
        logic [1:0] current_sel;
        logic       master_on;
        logic [3:0] common_pin_select;
    } ctrl_t;

    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } reg_req_t;

endpackage

// File: hw/lcd_bias_driver.sv
// software-driven 1/3 bias lcd common and segment pin driver
//
// Functional notes
// - one master enable for all common and segment pins
// - master off forces all lcd outputs ground
// - pin is lcd only when both enabled
// - common select bits 3..0 route pins
// - lcd drive ignores port direction setting
// - four levels: ground, third, two-thirds, supply
// - frame bit 7 selects frame 0/1
// - frame 0: com supply/third, seg ground/two-thirds
// - frame 1: com ground/two-thirds, seg supply/third
// - common data from port bits 0,1,2,4
// - segment data from its port bit
// - bits 6:5 select bias current
// - segment select bits route, reset zero
`timescale 1ns/1ps
`default_nettype none

module lcd_bias_driver
    import lcd_bias_pkg::*;
#(
    parameter int NCOM = NUM_COM,
    parameter int NSEG = NUM_SEG
) (
    input  wire logic             ref_clk,     // system clock, 50 MHz
    input  wire logic             rst,         // async reset, active high
    input  wire reg_req_t         req,         // register port request
    output logic      [7:0]       rdata,       // read data, cycle after rd
    input  wire logic [NCOM-1:0]  com_dir_out, // port direction for com pins
    input  wire logic [NSEG-1:0]  seg_dir_out, // port direction for seg pins
    output lcd_level_t            com_level [NCOM], // level per common pin
    output lcd_level_t            seg_level [NSEG], // level per segment pin
    output logic [NCOM-1:0]       com_lcd_act, // common pin owned by lcd
    output logic [NSEG-1:0]       seg_lcd_act, // segment pin owned by lcd
    output logic [1:0]            drive_current_sel // bias current code
);

    // ------------------------------------------------------------------
    // write decode
    // ------------------------------------------------------------------
    logic            wr_ctrl;
    logic            wr_seg_lo;
    logic            wr_seg_mid;
    logic            wr_seg_hi;
    logic            wr_port;
    logic            wr_dat0;
    logic            wr_dat1;
    logic            wr_dat2;
    logic [NSEG-1:0] seg_sel;
    logic [23:0]     seg_dat;

    assign wr_ctrl    = req.wr & (req.addr == ADDR_CTRL);
    assign wr_seg_lo  = req.wr & (req.addr == ADDR_SEG_LO);
    assign wr_seg_mid = req.wr & (req.addr == ADDR_SEG_MID);
    assign wr_seg_hi  = req.wr & (req.addr == ADDR_SEG_HI);
    assign wr_port    = req.wr & (req.addr == ADDR_PORT_A);
    assign wr_dat0    = req.wr & (req.addr == ADDR_SEG_DAT0);
    assign wr_dat1    = req.wr & (req.addr == ADDR_SEG_DAT1);
    assign wr_dat2    = req.wr & (req.addr == ADDR_SEG_DAT2);

    // ------------------------------------------------------------------
    // control register
    // ------------------------------------------------------------------
    ctrl_t ctrl_q;
    ctrl_t ctrl_d;

    always_comb begin
        ctrl_d = ctrl_q;
        if (wr_ctrl) begin
            ctrl_d = ctrl_t'(req.wdata);
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ctrl_q <= ctrl_t'(CTRL_RESET);
        end else begin
            ctrl_q <= ctrl_d;
        end
    end

    // ------------------------------------------------------------------
    // segment select, pins 7..0
    // ------------------------------------------------------------------
    logic [7:0] seg_sel_lo_q;
    logic [7:0] seg_sel_lo_d;

    always_comb begin
        seg_sel_lo_d = seg_sel_lo_q;
        if (wr_seg_lo) begin
            seg_sel_lo_d = req.wdata;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            seg_sel_lo_q <= SEG_SEL_RESET;
        end else begin
            seg_sel_lo_q <= seg_sel_lo_d;
        end
    end

    // ------------------------------------------------------------------
    // segment select, pins 15..8
    // ------------------------------------------------------------------
    logic [7:0] seg_sel_mid_q;
    logic [7:0] seg_sel_mid_d;

    always_comb begin
        seg_sel_mid_d = seg_sel_mid_q;
        if (wr_seg_mid) begin
            seg_sel_mid_d = req.wdata;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            seg_sel_mid_q <= SEG_SEL_RESET;
        end else begin
            seg_sel_mid_q <= seg_sel_mid_d;
        end
    end

    // ------------------------------------------------------------------
    // segment select, upper pins
    // ------------------------------------------------------------------
    logic [NSEG-17:0] seg_sel_hi_q;
    logic [NSEG-17:0] seg_sel_hi_d;

    always_comb begin
        seg_sel_hi_d = seg_sel_hi_q;
        if (wr_seg_hi) begin
            seg_sel_hi_d = req.wdata[NSEG-17:0];
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            seg_sel_hi_q <= '0;
        end else begin
            seg_sel_hi_q <= seg_sel_hi_d;
        end
    end

    assign seg_sel = {seg_sel_hi_q, seg_sel_mid_q, seg_sel_lo_q};

    // ------------------------------------------------------------------
    // first port data
    // ------------------------------------------------------------------
    logic [7:0] port_q;
    logic [7:0] port_d;

    always_comb begin
        port_d = port_q;
        if (wr_port) begin
            port_d = req.wdata;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            port_q <= PORT_RESET;
        end else begin
            port_q <= port_d;
        end
    end

    // ------------------------------------------------------------------
    // segment data, bits 7..0
    // ------------------------------------------------------------------
    logic [7:0] seg_dat0_q;
    logic [7:0] seg_dat0_d;

    always_comb begin
        seg_dat0_d = seg_dat0_q;
        if (wr_dat0) begin
            seg_dat0_d = req.wdata;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            seg_dat0_q <= PORT_RESET;
        end else begin
            seg_dat0_q <= seg_dat0_d;
        end
    end

    // ------------------------------------------------------------------
    // segment data, bits 15..8
    // ------------------------------------------------------------------
    logic [7:0] seg_dat1_q;
    logic [7:0] seg_dat1_d;

    always_comb begin
        seg_dat1_d = seg_dat1_q;
        if (wr_dat1) begin
            seg_dat1_d = req.wdata;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            seg_dat1_q <= PORT_RESET;
        end else begin
            seg_dat1_q <= seg_dat1_d;
        end
    end

    // ------------------------------------------------------------------
    // segment data, bits 23..16
    // ------------------------------------------------------------------
    logic [7:0] seg_dat2_q;
    logic [7:0] seg_dat2_d;

    always_comb begin
        seg_dat2_d = seg_dat2_q;
        if (wr_dat2) begin
            seg_dat2_d = req.wdata;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            seg_dat2_q <= PORT_RESET;
        end else begin
            seg_dat2_q <= seg_dat2_d;
        end
    end

    assign seg_dat = {seg_dat2_q, seg_dat1_q, seg_dat0_q};

    // ------------------------------------------------------------------
    // read data, valid the cycle after the read strobe
    // ------------------------------------------------------------------
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;

    always_comb begin
        rdata_d = 8'h00;
        if (req.rd) begin
            unique case (req.addr)
                ADDR_CTRL:     rdata_d = ctrl_q;
                ADDR_SEG_LO:   rdata_d = seg_sel_lo_q;
                ADDR_SEG_MID:  rdata_d = seg_sel_mid_q;
                ADDR_SEG_HI:   rdata_d = 8'(seg_sel_hi_q);
                ADDR_PORT_A:   rdata_d = port_q;
                ADDR_SEG_DAT0: rdata_d = seg_dat0_q;
                ADDR_SEG_DAT1: rdata_d = seg_dat1_q;
                ADDR_SEG_DAT2: rdata_d = seg_dat2_q;
            endcase
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign rdata             = rdata_q;
    assign drive_current_sel = ctrl_q.current_sel;

    // ------------------------------------------------------------------
    // level selection
    // ------------------------------------------------------------------
    logic [NCOM-1:0] com_data;
    assign com_data = {port_q[COM_DATA_BIT3], port_q[COM_DATA_BIT2],
                       port_q[COM_DATA_BIT1], port_q[COM_DATA_BIT0]};

    // common: frame 0 -> supply/third, frame 1 -> ground/two-thirds
    function automatic lcd_level_t com_pick(input logic fr, input logic d);
        if (!fr) begin
            com_pick = d ? LVL_SUPPLY : LVL_ONE_THIRD;
        end else begin
            com_pick = d ? LVL_GND : LVL_TWO_THIRD;
        end
    endfunction

    // segment: frame 0 -> ground/two-thirds, frame 1 -> supply/third
    function automatic lcd_level_t seg_pick(input logic fr, input logic d);
        if (!fr) begin
            seg_pick = d ? LVL_GND : LVL_TWO_THIRD;
        end else begin
            seg_pick = d ? LVL_SUPPLY : LVL_ONE_THIRD;
        end
    endfunction

    // direction inputs intentionally unused for lcd ownership
    logic dir_unused;
    assign dir_unused = ^{com_dir_out, seg_dir_out};

    genvar gi;
    generate
        for (gi = 0; gi < NCOM; gi++) begin : g_com
            assign com_lcd_act[gi] = ctrl_q.master_on &
                                     ctrl_q.common_pin_select[gi];
            assign com_level[gi] = com_lcd_act[gi] ?
                                   com_pick(ctrl_q.frame, com_data[gi]) :
                                   LVL_GND;
        end
        for (gi = 0; gi < NSEG; gi++) begin : g_seg
            assign seg_lcd_act[gi] = ctrl_q.master_on & seg_sel[gi];
            assign seg_level[gi] = seg_lcd_act[gi] ?
                                   seg_pick(ctrl_q.frame, seg_dat[gi]) :
                                   LVL_GND;
        end
    endgenerate

endmodule

`default_nettype wire

// File: test/lcd_bias_props.sv
// port checker for the lcd bias driver
`timescale 1ns/1ps
`default_nettype none
module lcd_bias_props
    import lcd_bias_pkg::*;
(
    input wire logic        ref_clk,            // clock
    input wire logic        rst,                // reset
    input wire reg_req_t    req,                // register request
    input wire logic [7:0]  rdata,              // read data
    input wire lcd_level_t  com_level [NUM_COM], // common levels
    input wire lcd_level_t  seg_level [NUM_SEG], // segment levels
    input wire logic [3:0]  com_lcd_act,        // common owned
    input wire logic [19:0] seg_lcd_act,        // segment owned
    input wire logic [1:0]  drive_current_sel   // current code
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    wire logic wr_ctrl = req.wr && req.addr == ADDR_CTRL;
    wire logic wr_port = req.wr && req.addr == ADDR_PORT_A;
    property p_act;
        wr_ctrl |=> com_lcd_act ==
            ($past(req.wdata[4]) ? $past(req.wdata[3:0]) : 4'h0);
    endproperty
    a_act: assert property (p_act) else $error("common ownership wrong");
    property p_isel; wr_ctrl |=> drive_current_sel == $past(req.wdata[6:5]); endproperty
    a_isel: assert property (p_isel) else $error("current code wrong");
    property p_rd;
        wr_ctrl ##1 (req.rd && req.addr == ADDR_CTRL) |=> rdata == $past(req.wdata, 2);
    endproperty
    a_rd: assert property (p_rd) else $error("control readback wrong");
    property p_off_com; !com_lcd_act[2] |-> com_level[2] == LVL_GND; endproperty
    a_off_com: assert property (p_off_com) else $error("idle common not ground");
    property p_off_seg; !seg_lcd_act[19] |-> seg_level[19] == LVL_GND; endproperty
    a_off_seg: assert property (p_off_seg) else $error("idle segment not ground");
    property p_frame;
        com_lcd_act[0] && seg_lcd_act[0] |-> com_level[0][0] != seg_level[0][0];
    endproperty
    a_frame: assert property (p_frame) else $error("frame sides mismatch");
    property p_dir; !$past(req.wr) |-> $stable(com_level[1]) && $stable(seg_level[5]); endproperty
    a_dir: assert property (p_dir) else $error("level moved without write");
    property p_dat;
        wr_port ##1 com_lcd_act[3] |->
            (com_level[3][1] == com_level[3][0]) == $past(req.wdata[4]);
    endproperty
    a_dat: assert property (p_dat) else $error("common data bit wrong");
    c_on: cover property (wr_ctrl && req.wdata[4]);
    c_pair: cover property (com_lcd_act[0] && seg_lcd_act[0]);
    c_gnd: cover property (com_lcd_act[0] && com_level[0] == LVL_GND);
endmodule
`default_nettype wire

// File: test/lcd_panel_model.sv
// lcd panel model: pixel on common 0 lit at full supply difference
`timescale 1ns/1ps
`default_nettype none
module lcd_panel_model
    import lcd_bias_pkg::*;
(
    input wire lcd_level_t    com_level [NUM_COM], // common electrodes
    input wire lcd_level_t    seg_level [NUM_SEG], // segment electrodes
    output logic [NUM_SEG-1:0] lit0               // pixels on common 0
);
    always_comb begin
        for (int s = 0; s < NUM_SEG; s++) begin
            lit0[s] = {com_level[0], seg_level[s]} inside {4'hC, 4'h3};
        end
    end
endmodule
`default_nettype wire

// File: test/test_software_lcd_bias_driver.sv
// self-checking bench for the lcd bias driver
`timescale 1ns/1ps
`default_nettype none
module test_software_lcd_bias_driver;
    import lcd_bias_pkg::*;
    logic        ref_clk = 1'b0;
    logic        rst = 1'b1;
    reg_req_t    req = '0;
    logic [7:0]  rdata;
    logic [3:0]  cdir = '0;
    logic [19:0] sdir = '0;
    lcd_level_t  com_level [4];
    lcd_level_t  seg_level [20];
    logic [3:0]  com_act;
    logic [19:0] seg_act, lit0;
    logic [1:0]  isel;
    logic [7:0]  r [8];
    int          error_cnt = 0;
    int          compares = 0;
    always #10 ref_clk = ~ref_clk;
    lcd_bias_driver i_dut (.ref_clk(ref_clk), .rst(rst), .req(req), .rdata(rdata),
        .com_dir_out(cdir), .seg_dir_out(sdir), .com_level(com_level),
        .seg_level(seg_level), .com_lcd_act(com_act), .seg_lcd_act(seg_act),
        .drive_current_sel(isel));
    lcd_panel_model i_panel (.com_level(com_level), .seg_level(seg_level), .lit0(lit0));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        req <= '{a, d, 1'b1, 1'b0};
        @(posedge ref_clk);
    endtask
    task automatic rd(input logic [2:0] a, input logic [7:0] exp);
        req <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge ref_clk);
        req <= '0;
        #1 chk(rdata, exp);
        @(posedge ref_clk);
    endtask
    // full swing when data set, high side is frame 0 common or frame 1 segment
    function automatic logic [7:0] lvl(logic act, logic f, logic d, logic com);
        logic h;
        h = f ^ com;
        return act ? {6'h00, d ~^ h, h} : 8'h00;
    endfunction
    // panel pixel lit when common and segment sit at opposite rails
    function automatic logic [7:0] lit(logic [7:0] c, logic [7:0] s);
        return 8'((c == 8'h03 && s == 8'h00) || (c == 8'h00 && s == 8'h03));
    endfunction
    task automatic summarize;
        if (error_cnt == 0 && compares > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        logic [23:0] ss, sd;
        void'($urandom(32'h30F70097));
        repeat (16) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        for (int a = 0; a < 8; a++) rd(3'(a), 8'h00);
        for (int i = 0; i < 40; i++) begin
            for (int k = 0; k < 8; k++) r[k] = (i < 2) ? 8'hFF : 8'($urandom);
            r[0][4] = (i == 0) ? 1'b0 : r[0][4];
            r[0][7] = i[0];
            cdir <= 4'($urandom);
            sdir <= 20'($urandom);
            for (int a = 1; a <= 8; a++) wr(3'(a), r[3'(a)]);
            for (int a = 0; a < 8; a++) rd(3'(a), (a == 3) ? {4'h0, r[3][3:0]} : r[a]);
            #1 chk(8'(isel), {6'h00, r[0][6:5]});
            ss = {r[3], r[2], r[1]};
            sd = {r[7], r[6], r[5]};
            for (int c = 0; c < 4; c++) begin
                chk(8'(com_act[c]), 8'(r[0][4] & r[0][c]));
                chk(8'(com_level[c]), lvl(r[0][4] & r[0][c], r[0][7],
                    r[4][c == 3 ? 4 : c], 1'b1));
            end
            for (int s = 0; s < 20; s++) begin
                chk(8'(seg_act[s]), 8'(r[0][4] & ss[s]));
                chk(8'(seg_level[s]), lvl(r[0][4] & ss[s], r[0][7], sd[s], 1'b0));
                chk(8'(lit0[s]),
                    lit(lvl(r[0][4] & r[0][0], r[0][7], r[4][0], 1'b1),
                        lvl(r[0][4] & ss[s], r[0][7], sd[s], 1'b0)));
            end
        end
        summarize();
    end
endmodule
bind lcd_bias_driver lcd_bias_props i_props (.ref_clk(ref_clk), .rst(rst),
    .req(req), .rdata(rdata), .com_level(com_level), .seg_level(seg_level),
    .com_lcd_act(com_lcd_act), .seg_lcd_act(seg_lcd_act),
    .drive_current_sel(drive_current_sel));
`default_nettype wire
